// file: common/mpl_defines.svh
// Summary of operation
// - Thermal protection works only while its enable bit is 1; reset value 0.
// - Enabled thermal model blocks output after inverse-time delay, faster at higher current.
// - One-minute level accepted above continuous level up to 200; default 150.
// - Continuous level accepted from 50, below one-minute level and 150; default 100.
// - Cooling style 0 is shaft fan, 1 is separate fan; default 0.
// - Thermal levels and cooling style are editable only while thermal enable is 1.
// - Warning level 30 to 150 default 150; warning time 0.0 to 30.0 s default 10.0.
// - Output selector 5 routes overload signal; selectors range 0 to 19, default 17.
// - Overload trip enabled by default; its level and time editable only while enabled.
// - Current above trip level for trip time blocks output; time 0.0 to 60.0 s.
// - Overload trip with trip time above 30 s resets the automatic restart count.
// - Accelerating with its stall bit set: decelerate while current exceeds stall level.
// - Constant speed with its stall bit set: decelerate while current exceeds stall level.
// - Decelerating with its stall bit set: hold the ramp while DC link is at limit.
// - Stall bits: bit 0 accel, bit 1 constant speed, bit 2 decel; default 000.
// - Stall level 30 to 200 percent of rated current; default 150.
// - Output selector 7 shows stall condition regardless of stall enable bits.
// - Stall speed changes use the configured accel and decel ramp rates.
// - Ramp durations may exceed configured times while stall logic intervenes.
`ifndef MPL_DEFINES_SVH
`define MPL_DEFINES_SVH
`define MPL_A_THERM_CTRL   4'h0
`define MPL_A_ONE_MIN      4'h1
`define MPL_A_CONT         4'h2
`define MPL_A_WARN_LVL     4'h3
`define MPL_A_WARN_TIME    4'h4
`define MPL_A_TRIP_CTRL    4'h5
`define MPL_A_TRIP_LVL     4'h6
`define MPL_A_TRIP_TIME    4'h7
`define MPL_A_STALL_BITS   4'h8
`define MPL_A_STALL_LVL    4'h9
`define MPL_A_RELAY_SEL    4'ha
`define MPL_A_OUT2_SEL     4'hb
`define MPL_A_STATUS       4'hc
`define MPL_A_THERM_ACC    4'hd
`define MPL_B_EN           0
`define MPL_B_COOL         1
`define MPL_S_OL           0
`define MPL_S_STALL        1
`define MPL_S_TRIP         2
`define MPL_S_THERM        3
`define MPL_S_OVLD         4
`define MPL_S_REJECT       5
`define MPL_SB_ACCEL       0
`define MPL_SB_CONST       1
`define MPL_SB_DECEL       2
`define MPL_RST_ONE_MIN    8'h96
`define MPL_RST_CONT       8'h64
`define MPL_RST_WARN_LVL   8'h96
`define MPL_RST_WARN_TIME  10'h064
`define MPL_RST_TRIP_LVL   8'hb4
`define MPL_RST_TRIP_TIME  10'h258
`define MPL_RST_STALL_LVL  8'h96
`define MPL_RST_STALL_BITS 3'h0
`define MPL_RST_TRIP_EN    1'b1
`define MPL_RST_SEL        5'h11
`define MPL_LVL_30         8'h1e
`define MPL_LVL_50         8'h32
`define MPL_LVL_150        8'h96
`define MPL_LVL_200        8'hc8
`define MPL_WARN_TIME_MAX  10'h12c
`define MPL_TRIP_TIME_MAX  10'h258
`define MPL_RESTART_TIME   10'h12c
`define MPL_SEL_MAX        5'h13
`define MPL_SEL_OVERLOAD   5'h05
`define MPL_SEL_STALL      5'h07
`define MPL_MINUTE_TICKS   20'h00258
`define MPL_TICK_NS        100000000
`define MPL_CLK_NS         10
`endif

// file: common/mpl_pkg.sv
package mpl_pkg;
  typedef enum logic [1:0] {
    MPL_STOP  = 2'h0,
    MPL_ACCEL = 2'h1,
    MPL_CONST = 2'h3,
    MPL_DECEL = 2'h2
  } mpl_phase_t;
  typedef enum logic [1:0] {
    MPL_RUN     = 2'h0,
    MPL_TRIPPED = 2'h1
  } mpl_state_t;
  typedef struct packed {
    logic [7:0] current_pct;
    mpl_phase_t phase;
    logic       dc_at_limit;
  } mpl_meas_t;
  typedef struct packed {
    logic hold;
    logic decel;
  } mpl_ramp_t;
endpackage

// file: core/mpl_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_timer #(
  parameter int W = 10
) (
  input  wire logic         clock_in,   // System clock
  input  wire logic         reset_n_in, // Sync reset, active low
  input  wire logic         ce_in,      // Clock enable
  input  wire logic         tick_in,    // Tenth-second tick
  input  wire logic         cond_in,    // Condition being timed
  input  wire logic [W-1:0] limit_in,   // Required time in ticks
  output logic              done_out    // Condition held for limit
);
  logic [W-1:0] count;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      count <= '0;
    end else if (ce_in) begin
      if (!cond_in) begin
        count <= '0;
      end else if (tick_in && count < limit_in) begin
        count <= count + 1'b1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= cond_in && (count >= limit_in);
    end
  end
  a_timer_drop : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ce_in && !cond_in |=> !done_out) else $error("timer output did not drop");
  a_timer_wait : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $rose(done_out) |-> $past(count) >= $past(limit_in))
    else $error("timer fired early");
endmodule
`default_nettype wire

// file: core/motor_protection_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpl_defines.svh"
module motor_protection_logic #(
  parameter int TICK_CYCLES = `MPL_TICK_NS / `MPL_CLK_NS,
  parameter int ACC_W       = 20
) (
  input  wire logic              clock_in,          // 100 MHz clock
  input  wire logic              reset_n_in,        // Sync reset, active low
  input  wire logic              ce_in,             // Clock enable, freezes state
  input  wire mpl_pkg::mpl_meas_t meas_in,          // Current, phase, DC-link limit
  input  wire logic              fault_reset_in,    // Clear latched trip
  input  wire logic [3:0]        addr_in,           // Register address
  input  wire logic [15:0]       wr_data_in,        // Write data
  input  wire logic              wr_in,             // Write strobe
  input  wire logic              rd_in,             // Read strobe
  output logic [15:0]            rd_data_out,       // Read data, cycle after strobe
  output logic                   trip_out,          // Block inverter output
  output logic                   restart_clear_out, // Reset restart counter pulse
  output mpl_pkg::mpl_ramp_t     ramp_out,          // Ramp hold / decelerate
  output logic                   relay_out,         // Multi-function relay
  output logic                   output2_out        // Multi-function output 2
);
  logic              therm_en;
  logic              cool_sep;
  logic [7:0]        one_min;
  logic [7:0]        cont;
  logic [7:0]        warn_lvl;
  logic [9:0]        warn_time;
  logic              trip_en;
  logic [7:0]        trip_lvl;
  logic [9:0]        trip_time;
  logic [2:0]        stall_bits;
  logic [7:0]        stall_lvl;
  logic [4:0]        relay_sel;
  logic [4:0]        out2_sel;
  logic              reject;
  logic [23:0]       tick_cnt;
  logic              tick;
  logic [ACC_W-1:0]  acc;
  logic              ol;
  logic              ovld_trip_req;
  logic              therm_trip_req;
  logic              therm_cause;
  logic              ovld_cause;
  logic              stall;
  mpl_pkg::mpl_state_t state;
  logic [7:0]        v8;
  logic [9:0]        v10;
  logic [4:0]        v5;
  logic [7:0]        cur;
  logic              wr_ok;
  logic              next_reject;

  function automatic logic in_range8(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi);
    in_range8 = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [ACC_W-1:0] therm_limit(input logic [7:0] hi,
                                                   input logic [7:0] lo);
    logic [ACC_W-1:0] d;
    d = ACC_W'(hi - lo);
    therm_limit = ACC_W'(d * `MPL_MINUTE_TICKS);
  endfunction

  function automatic logic sel_fn(input logic [4:0] sel, input logic ol_v,
                                  input logic st_v);
    case (sel)
      `MPL_SEL_OVERLOAD: sel_fn = ol_v;
      `MPL_SEL_STALL:    sel_fn = st_v;
      default:           sel_fn = 1'b0;
    endcase
  endfunction

  assign v8  = wr_data_in[7:0];
  assign v10 = wr_data_in[9:0];
  assign v5  = wr_data_in[4:0];
  assign cur = meas_in.current_pct;

  // Write validation: rejected values leave the register unchanged
  always_comb begin
    wr_ok = 1'b0;
    case (addr_in)
      `MPL_A_THERM_CTRL: wr_ok = 1'b1;
      `MPL_A_ONE_MIN:    wr_ok = therm_en && v8 > cont && v8 <= `MPL_LVL_200;
      `MPL_A_CONT:       wr_ok = therm_en && v8 >= `MPL_LVL_50 && v8 < one_min
                                 && v8 < `MPL_LVL_150;
      `MPL_A_WARN_LVL:   wr_ok = in_range8(v8, `MPL_LVL_30, `MPL_LVL_150);
      `MPL_A_WARN_TIME:  wr_ok = v10 <= `MPL_WARN_TIME_MAX;
      `MPL_A_TRIP_CTRL:  wr_ok = 1'b1;
      `MPL_A_TRIP_LVL:   wr_ok = trip_en && in_range8(v8, `MPL_LVL_30, `MPL_LVL_200);
      `MPL_A_TRIP_TIME:  wr_ok = trip_en && v10 <= `MPL_TRIP_TIME_MAX;
      `MPL_A_STALL_BITS: wr_ok = 1'b1;
      `MPL_A_STALL_LVL:  wr_ok = in_range8(v8, `MPL_LVL_30, `MPL_LVL_200);
      `MPL_A_RELAY_SEL:  wr_ok = v5 <= `MPL_SEL_MAX;
      `MPL_A_OUT2_SEL:   wr_ok = v5 <= `MPL_SEL_MAX;
      default:           wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      therm_en   <= 1'b0;
      cool_sep   <= 1'b0;
      one_min    <= `MPL_RST_ONE_MIN;
      cont       <= `MPL_RST_CONT;
      warn_lvl   <= `MPL_RST_WARN_LVL;
      warn_time  <= `MPL_RST_WARN_TIME;
      trip_en    <= `MPL_RST_TRIP_EN;
      trip_lvl   <= `MPL_RST_TRIP_LVL;
      trip_time  <= `MPL_RST_TRIP_TIME;
      stall_bits <= `MPL_RST_STALL_BITS;
      stall_lvl  <= `MPL_RST_STALL_LVL;
      relay_sel  <= `MPL_RST_SEL;
      out2_sel   <= `MPL_RST_SEL;
    end else if (ce_in && wr_in && wr_ok) begin
      case (addr_in)
        `MPL_A_THERM_CTRL: begin
          therm_en <= wr_data_in[`MPL_B_EN];
          if (therm_en) begin
            cool_sep <= wr_data_in[`MPL_B_COOL];
          end
        end
        `MPL_A_ONE_MIN:    one_min    <= v8;
        `MPL_A_CONT:       cont       <= v8;
        `MPL_A_WARN_LVL:   warn_lvl   <= v8;
        `MPL_A_WARN_TIME:  warn_time  <= v10;
        `MPL_A_TRIP_CTRL:  trip_en    <= wr_data_in[`MPL_B_EN];
        `MPL_A_TRIP_LVL:   trip_lvl   <= v8;
        `MPL_A_TRIP_TIME:  trip_time  <= v10;
        `MPL_A_STALL_BITS: stall_bits <= wr_data_in[2:0];
        `MPL_A_STALL_LVL:  stall_lvl  <= v8;
        `MPL_A_RELAY_SEL:  relay_sel  <= v5;
        `MPL_A_OUT2_SEL:   out2_sel   <= v5;
        default: begin
        end
      endcase
    end
  end

  // Sticky reject flag; a new reject wins over a write-one clear
  always_comb begin
    next_reject = reject;
    if (wr_in && addr_in == `MPL_A_STATUS && wr_data_in[`MPL_S_REJECT]) begin
      next_reject = 1'b0;
    end
    if (wr_in && !wr_ok && addr_in != `MPL_A_STATUS && addr_in != `MPL_A_THERM_ACC) begin
      next_reject = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      reject <= 1'b0;
    end else if (ce_in) begin
      reject <= next_reject;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 16'h0000;
    end else if (ce_in) begin
      rd_data_out <= 16'h0000;
      if (rd_in) begin
        case (addr_in)
          `MPL_A_THERM_CTRL: rd_data_out <= {14'h0000, cool_sep, therm_en};
          `MPL_A_ONE_MIN:    rd_data_out <= {8'h00, one_min};
          `MPL_A_CONT:       rd_data_out <= {8'h00, cont};
          `MPL_A_WARN_LVL:   rd_data_out <= {8'h00, warn_lvl};
          `MPL_A_WARN_TIME:  rd_data_out <= {6'h00, warn_time};
          `MPL_A_TRIP_CTRL:  rd_data_out <= {15'h0000, trip_en};
          `MPL_A_TRIP_LVL:   rd_data_out <= {8'h00, trip_lvl};
          `MPL_A_TRIP_TIME:  rd_data_out <= {6'h00, trip_time};
          `MPL_A_STALL_BITS: rd_data_out <= {13'h0000, stall_bits};
          `MPL_A_STALL_LVL:  rd_data_out <= {8'h00, stall_lvl};
          `MPL_A_RELAY_SEL:  rd_data_out <= {11'h000, relay_sel};
          `MPL_A_OUT2_SEL:   rd_data_out <= {11'h000, out2_sel};
          `MPL_A_STATUS:     rd_data_out <= {10'h000, reject, ovld_cause, therm_cause,
                                             trip_out, stall, ol};
          `MPL_A_THERM_ACC:  rd_data_out <= acc[ACC_W-1 -: 16];
          default:           rd_data_out <= 16'h0000;
        endcase
      end
    end
  end

  // Tenth-second time base
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      tick_cnt <= 24'h000000;
      tick     <= 1'b0;
    end else if (ce_in) begin
      tick <= (tick_cnt == 24'(TICK_CYCLES - 1));
      if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
        tick_cnt <= 24'h000000;
      end else begin
        tick_cnt <= tick_cnt + 24'h000001;
      end
    end
  end

  // Thermal model: heat accumulates with excess over the continuous level,
  // so the time to reach the limit falls as current rises. One minute at
  // the one-minute level reaches the limit exactly.
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      acc <= '0;
    end else if (ce_in) begin
      if (!therm_en) begin
        acc <= '0;
      end else if (tick) begin
        if (cur > cont) begin
          // Saturate at the trip limit so a long overload cannot wrap the sum
          if (!therm_trip_req) begin
            acc <= acc + ACC_W'(cur - cont);
          end
        end else if (cool_sep || meas_in.phase != mpl_pkg::MPL_STOP) begin
          acc <= (acc > ACC_W'(cont - cur)) ? acc - ACC_W'(cont - cur) : '0;
        end else begin
          // Shaft fan stands still: half the cooling
          acc <= (acc > ACC_W'((cont - cur) >> 1)) ? acc - ACC_W'((cont - cur) >> 1) : '0;
        end
      end
    end
  end

  assign therm_trip_req = therm_en && acc >= therm_limit(one_min, cont);

  mpl_timer #(.W(10)) u_warn (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .tick_in    (tick),
    .cond_in    (cur > warn_lvl),
    .limit_in   (warn_time),
    .done_out   (ol)
  );

  mpl_timer #(.W(10)) u_trip (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .tick_in    (tick),
    .cond_in    (trip_en && cur > trip_lvl),
    .limit_in   (trip_time),
    .done_out   (ovld_trip_req)
  );

  // Trip latch, cleared by fault reset once no request is pending
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state             <= mpl_pkg::MPL_RUN;
      trip_out          <= 1'b0;
      therm_cause       <= 1'b0;
      ovld_cause        <= 1'b0;
      restart_clear_out <= 1'b0;
    end else if (ce_in) begin
      restart_clear_out <= 1'b0;
      case (state)
        mpl_pkg::MPL_RUN: begin
          if (therm_trip_req || ovld_trip_req) begin
            state       <= mpl_pkg::MPL_TRIPPED;
            trip_out    <= 1'b1;
            therm_cause <= therm_trip_req;
            ovld_cause  <= ovld_trip_req;
            restart_clear_out <= ovld_trip_req && trip_time > `MPL_RESTART_TIME;
          end
        end
        mpl_pkg::MPL_TRIPPED: begin
          if (fault_reset_in && !therm_trip_req && !ovld_trip_req) begin
            state       <= mpl_pkg::MPL_RUN;
            trip_out    <= 1'b0;
            therm_cause <= 1'b0;
            ovld_cause  <= 1'b0;
          end
        end
        default: begin
          state    <= mpl_pkg::MPL_TRIPPED;
          trip_out <= 1'b1;
        end
      endcase
    end
  end

  // Stall prevention; the external ramp uses its accel and decel times for
  // these moves and no time limit applies, so ramps may stretch
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ramp_out <= '0;
      stall    <= 1'b0;
    end else if (ce_in) begin
      ramp_out.decel <= cur > stall_lvl &&
        ((meas_in.phase == mpl_pkg::MPL_ACCEL && stall_bits[`MPL_SB_ACCEL]) ||
         (meas_in.phase == mpl_pkg::MPL_CONST && stall_bits[`MPL_SB_CONST]));
      ramp_out.hold  <= meas_in.phase == mpl_pkg::MPL_DECEL && meas_in.dc_at_limit
                        && stall_bits[`MPL_SB_DECEL];
      stall <= (cur > stall_lvl && (meas_in.phase == mpl_pkg::MPL_ACCEL ||
                                    meas_in.phase == mpl_pkg::MPL_CONST)) ||
               (meas_in.phase == mpl_pkg::MPL_DECEL && meas_in.dc_at_limit);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      relay_out   <= 1'b0;
      output2_out <= 1'b0;
    end else if (ce_in) begin
      relay_out   <= sel_fn(relay_sel, ol, stall);
      output2_out <= sel_fn(out2_sel, ol, stall);
    end
  end

  a_therm_off_safe : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !therm_en |-> !therm_trip_req) else $error("thermal trip while disabled");
  a_level_order : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    one_min > cont && one_min <= `MPL_LVL_200) else $error("one-minute level out of range");
  a_cont_range : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cont >= `MPL_LVL_50 && cont < `MPL_LVL_150) else $error("continuous level out of range");
  a_edit_lock : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    wr_in && !therm_en && addr_in == `MPL_A_ONE_MIN |=> $stable(one_min))
    else $error("thermal level changed while locked");
  a_relay_route : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ce_in && relay_sel == `MPL_SEL_OVERLOAD |=> relay_out == $past(ol))
    else $error("relay does not follow overload signal");
  a_trip_latch : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ce_in && (therm_trip_req || ovld_trip_req) |=> trip_out)
    else $error("trip request did not block output");
  a_stall_accel : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ce_in && meas_in.phase == mpl_pkg::MPL_ACCEL && stall_bits[`MPL_SB_ACCEL] && cur > stall_lvl
    |=> ramp_out.decel) else $error("no decel on accel stall");
  a_stall_hold : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ce_in && meas_in.phase == mpl_pkg::MPL_DECEL && !stall_bits[`MPL_SB_DECEL]
    |=> !ramp_out.hold) else $error("hold without decel enable");
  a_restart_clear : assert property (@(posedge clock_in) disable iff (!reset_n_in)
    restart_clear_out |-> trip_out && ovld_cause && trip_time > `MPL_RESTART_TIME)
    else $error("restart clear without long overload trip");
  c_trip : cover property (@(posedge clock_in) disable iff (!reset_n_in) $rose(trip_out));
  c_warn : cover property (@(posedge clock_in) disable iff (!reset_n_in) $rose(ol));
  c_hold : cover property (@(posedge clock_in) disable iff (!reset_n_in) ramp_out.hold);
endmodule
`default_nettype wire

// file: tb/mpl_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpl_motor_model (
  input  wire logic               clock_in,   // System clock
  input  wire logic               reset_n_in, // Sync reset, active low
  input  wire logic [7:0]         load_in,    // Commanded load current
  input  wire mpl_pkg::mpl_phase_t phase_in,  // Commanded ramp phase
  input  wire logic               regen_in,   // Regeneration pushes DC link up
  output mpl_pkg::mpl_meas_t      meas_out    // Measurement seen by the inverter
);
  // Sensor path adds one cycle of latency, as a real sampler would
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      meas_out <= '0;
    end else begin
      meas_out.current_pct <= load_in;
      meas_out.phase       <= phase_in;
      meas_out.dc_at_limit <= regen_in;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_motor_protection_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpl_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_motor_protection_logic;
  localparam int TICK = 4;
  logic clock_in = 1'b0, reset_n_in = 1'b0, fault_reset_in = 1'b0;
  logic wr_in = 1'b0, rd_in = 1'b0, regen = 1'b0, ce_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wr_data_in = 16'h0000, rd_data_out;
  logic [7:0] load = 8'h00;
  mpl_pkg::mpl_phase_t phase = mpl_pkg::MPL_STOP;
  mpl_pkg::mpl_meas_t meas;
  mpl_pkg::mpl_ramp_t ramp_out;
  logic trip_out, restart_clear_out, relay_out, output2_out, pulse_seen;
  int checks = 0, miscompares = 0;
  logic [15:0] rst_val [12] = '{16'h0000, 16'h0096, 16'h0064, 16'h0096, 16'h0064, 16'h0001,
                                16'h00b4, 16'h0258, 16'h0000, 16'h0096, 16'h0011, 16'h0011};
  always #5 clock_in = ~clock_in;
  mpl_motor_model model_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .load_in(load),
    .phase_in(phase), .regen_in(regen), .meas_out(meas));
  motor_protection_logic #(.TICK_CYCLES(TICK)) dut_u (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .ce_in(ce_in), .meas_in(meas), .fault_reset_in(fault_reset_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .trip_out(trip_out), .restart_clear_out(restart_clear_out),
    .ramp_out(ramp_out), .relay_out(relay_out), .output2_out(output2_out));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1; addr_in <= a; wr_data_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge clock_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 `CHK(n, e, rd_data_out)
  endtask
  task automatic drive(input logic [7:0] c, input mpl_pkg::mpl_phase_t p, input logic r);
    @(posedge clock_in);
    load <= c; phase <= p; regen <= r;
    repeat (5) @(posedge clock_in);
    #1;
  endtask
  task automatic check_reset_values;
    for (int i = 0; i < 12; i++) rd(i[3:0], rst_val[i], "reset value");
  endtask
  task automatic check_rejects;
    wr(`MPL_A_WARN_LVL, 16'h001d);
    rd(`MPL_A_WARN_LVL, 16'h0096, "warn level below 30");
    wr(`MPL_A_RELAY_SEL, 16'h0014);
    rd(`MPL_A_RELAY_SEL, 16'h0011, "selector above 19");
    wr(`MPL_A_ONE_MIN, 16'h0080);
    rd(`MPL_A_ONE_MIN, 16'h0096, "one-minute level while disabled");
    wr(`MPL_A_THERM_CTRL, 16'h0002);
    rd(`MPL_A_THERM_CTRL, 16'h0000, "cooling style while disabled");
    rd(`MPL_A_STATUS, 16'h0020, "reject flag");
    wr(`MPL_A_STATUS, 16'h0020);
    rd(`MPL_A_STATUS, 16'h0000, "reject flag cleared");
    rd(4'he, 16'h0000, "unmapped read");
  endtask
  task automatic check_stall;
    wr(`MPL_A_STALL_BITS, 16'h0003);
    wr(`MPL_A_RELAY_SEL, 16'h0007);
    drive(8'ha0, mpl_pkg::MPL_ACCEL, 1'b0);
    `CHK("decel in accel", 1'b1, ramp_out.decel)
    `CHK("relay stall", 1'b1, relay_out)
    drive(8'ha0, mpl_pkg::MPL_CONST, 1'b0);
    `CHK("decel at constant speed", 1'b1, ramp_out.decel)
    drive(8'h96, mpl_pkg::MPL_CONST, 1'b0);
    `CHK("no decel at level", 1'b0, ramp_out.decel)
    drive(8'h00, mpl_pkg::MPL_DECEL, 1'b1);
    `CHK("no hold with decel bit clear", 1'b0, ramp_out.hold)
    `CHK("relay stall ignores bits", 1'b1, relay_out)
    wr(`MPL_A_STALL_BITS, 16'h0004);
    drive(8'h00, mpl_pkg::MPL_DECEL, 1'b1);
    `CHK("hold in decel", 1'b1, ramp_out.hold)
    drive(8'h00, mpl_pkg::MPL_STOP, 1'b0);
    `CHK("hold released", 1'b0, ramp_out.hold)
  endtask
  task automatic check_warning;
    int i;
    wr(`MPL_A_WARN_LVL, 16'h0064);
    wr(`MPL_A_WARN_TIME, 16'h0002);
    wr(`MPL_A_OUT2_SEL, 16'h0005);
    wr(`MPL_A_RELAY_SEL, 16'h0005);
    @(posedge clock_in);
    load <= 8'h78;
    repeat (3) @(posedge clock_in);
    #1 `CHK("warning too early", 1'b0, output2_out)
    for (i = 0; i < 30 && output2_out !== 1'b1; i++) @(posedge clock_in);
    #1 `CHK("warning after time", 1'b1, output2_out)
    `CHK("relay warning", 1'b1, relay_out)
    @(posedge clock_in);
    ce_in <= 1'b0;
    drive(8'h5a, mpl_pkg::MPL_STOP, 1'b0);
    `CHK("warning held while frozen", 1'b1, output2_out)
    @(posedge clock_in);
    ce_in <= 1'b1;
    drive(8'h5a, mpl_pkg::MPL_STOP, 1'b0);
    `CHK("warning dropped", 1'b0, output2_out)
    `CHK("relay warning dropped", 1'b0, relay_out)
  endtask
  task automatic check_trip;
    int i;
    wr(`MPL_A_TRIP_LVL, 16'h0064);
    wr(`MPL_A_TRIP_TIME, 16'h012d);
    @(posedge clock_in);
    load <= 8'h78;
    repeat (1000) @(posedge clock_in);
    #1 `CHK("trip too early", 1'b0, trip_out)
    for (i = 0; i < 400 && trip_out !== 1'b1; i++) @(posedge clock_in);
    #1 `CHK("overload trip", 1'b1, trip_out)
    `CHK("restart counter cleared", 1'b1, pulse_seen)
    @(posedge clock_in);
    load <= 8'h00; fault_reset_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    fault_reset_in <= 1'b0;
    #1 `CHK("trip cleared", 1'b0, trip_out)
  endtask
  task automatic check_thermal;
    int i;
    wr(`MPL_A_TRIP_CTRL, 16'h0000);
    wr(`MPL_A_THERM_CTRL, 16'h0001);
    wr(`MPL_A_THERM_CTRL, 16'h0003);
    rd(`MPL_A_THERM_CTRL, 16'h0003, "cooling style when enabled");
    wr(`MPL_A_CONT, 16'h0096);
    rd(`MPL_A_CONT, 16'h0064, "continuous level 150");
    wr(`MPL_A_ONE_MIN, 16'h0050);
    rd(`MPL_A_ONE_MIN, 16'h0096, "one-minute below continuous");
    wr(`MPL_A_ONE_MIN, 16'h006e);
    rd(`MPL_A_ONE_MIN, 16'h006e, "one-minute accepted");
    @(posedge clock_in);
    load <= 8'hc8;
    for (i = 0; i < 400 && trip_out !== 1'b1; i++) @(posedge clock_in);
    #1 `CHK("thermal trip", 1'b1, trip_out)
    `CHK("thermal trip not instant", 1'b1, i > 150)
    rd(`MPL_A_THERM_ACC, 16'h0177, "thermal sum held at limit");
  endtask
  always @(posedge clock_in) if (restart_clear_out === 1'b1) pulse_seen <= 1'b1;
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    pulse_seen = 1'b0;
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    check_reset_values();
    check_rejects();
    check_stall();
    check_warning();
    check_trip();
    check_thermal();
    report_and_stop();
  end
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
